/* File: common/cwoc_pkg.sv */
// Package with register map, field positions and timing for the counter.
package cwoc_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  // Register byte offsets.
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_CMD       = 8'h04;
  localparam logic [7:0]  OFF_UPPER     = 8'h08;
  localparam logic [7:0]  OFF_LOWER     = 8'h0c;
  localparam logic [7:0]  OFF_ZFL       = 8'h10;
  localparam logic [7:0]  OFF_CPRE      = 8'h14;
  localparam logic [7:0]  OFF_RPRE      = 8'h18;
  localparam logic [7:0]  OFF_GAP       = 8'h1c;
  localparam logic [7:0]  OFF_ON_TH     = 8'h20;
  localparam logic [7:0]  OFF_OFF_TH    = 8'h24;
  localparam logic [7:0]  OFF_HYST_ON   = 8'h28;
  localparam logic [7:0]  OFF_HYST_OFF  = 8'h2c;
  localparam logic [7:0]  OFF_STATUS    = 8'h30;
  localparam logic [7:0]  OFF_CLEAR     = 8'h34;
  localparam logic [7:0]  OFF_ENABLE    = 8'h38;
  localparam logic [7:0]  OFF_COUNT     = 8'h3c;
  localparam logic [7:0]  OFF_REV       = 8'h40;
  localparam logic [7:0]  OFF_QERR      = 8'h44;
  localparam logic [7:0]  OFF_LIVE      = 8'h48;
  // Control register fields.
  localparam int          CT_A_EN       = 0;
  localparam int          CT_A_LVL      = 1;
  localparam int          CT_B_EN       = 2;
  localparam int          CT_B_LVL      = 3;
  localparam int          CT_Z_EN       = 4;
  localparam int          CT_Z_LVL      = 5;
  localparam int          CT_GAP_EN     = 6;
  localparam int          CT_OUT_EN     = 7;
  localparam int          CT_OUT_LVL    = 8;
  localparam int          CT_MODE_LO    = 9;
  localparam int          CTRL_W        = 11;
  // Command register fields, write one to act.
  localparam int          CM_LOAD_CNT   = 0;
  localparam int          CM_LOAD_REV   = 1;
  localparam int          CM_QERR_CLR   = 2;
  // Status, clear and enable fields.
  localparam int          ST_UPPER      = 0;
  localparam int          ST_LOWER      = 1;
  localparam int          ST_QERR       = 2;
  localparam int          ST_ZFREQ      = 3;
  localparam int          ST_GAP        = 4;
  localparam int          ST_WIN_ON     = 5;
  localparam int          ST_WIN_OFF    = 6;
  localparam int          ST_W          = 7;
  // Window measure selection.
  localparam logic [1:0]  MODE_COUNT    = 2'h0;
  localparam logic [1:0]  MODE_FREQ     = 2'h1;
  localparam logic [1:0]  MODE_PW       = 2'h2;
  localparam logic [1:0]  MODE_AVG      = 2'h3;
  // Pulse width is in microseconds and frequency in hertz.
  localparam logic [31:0] PW_RECIP_NUM  = 32'h000f4240;
  localparam logic [31:0] MIN_POS       = 32'h00000001;
  localparam logic [31:0] ZERO          = 32'h00000000;
  // Microsecond tick derived from the clock rate.
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          US_IN_NS      = 1000;
  localparam int          US_CYCLES     = US_IN_NS / CLK_PERIOD_NS;
  localparam logic [6:0]  US_LAST       = 7'(US_CYCLES - 1);
  typedef enum logic {CWOC_WIN_OFF, CWOC_WIN_ON} cwoc_win_e;
endpackage : cwoc_pkg

/* File: design/cwoc_top.sv */
// Counter channel with wrap, presets, input forcing, gap alarm and window.
//
// Overview of operation
// RQ1: Writing quad error clear zeroes error count.
// RQ2: Upward at upper limit loads lower limit.
// RQ3: Downward at lower limit loads upper limit.
// RQ4: Frequency or average below limit raises alarm.
// RQ5: Separate presets for count and revolution count.
// RQ6: Forced level replaces A, B, Z pins.
// RQ7: Gap beyond limit in microseconds raises alarm.
// RQ8: Window on threshold over selected on measure.
// RQ9: Window off threshold over selected off measure.
// RQ10: Frequency mode thresholds floored at zero limit.
// RQ11: Pulse width thresholds floored at reciprocal.
// RQ12: Pulse width thresholds at or below zero become one.
// RQ13: On hysteresis lowers on level, off if nonpositive.
// RQ14: Off hysteresis lowers off level, off if nonpositive.
// RQ15: Output force replaces window state on output.
// RQ16: Window on at on level, off at off level.
// RQ17: Gap alarm evaluated only when enabled.
// RQ18: Wrap flags latch until written one clears.
`timescale 1ns/10ps
module cwoc_top (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        a_i,
  input  wire logic        b_i,
  input  wire logic        z_i,
  input  wire logic [31:0] freq_i,
  input  wire logic [31:0] freq_avg_i,
  input  wire logic [31:0] pulse_width_i,
  input  wire logic [31:0] accel_i,
  output logic             out_o,
  output logic             irq_o
);

  // Write decode; the write lands on the edge where pready is seen high.
  function automatic logic wr_hit(input logic [7:0] off,
                                  input logic [7:0] addr,
                                  input logic       acc);
    wr_hit = acc && (addr == off);
  endfunction : wr_hit

  // Signed maximum, used for every threshold floor.
  function automatic logic [31:0] smax(input logic [31:0] x,
                                       input logic [31:0] y);
    smax = ($signed(x) < $signed(y)) ? y : x;
  endfunction : smax

  // Effective threshold after the mode-dependent clamps.
  function automatic logic [31:0] eff_th(input logic [31:0] th,
                                         input logic [1:0]  mode,
                                         input logic [31:0] zfl,
                                         input logic [31:0] recip);
    logic [31:0] r;
    r = th;
    if (mode == cwoc_pkg::MODE_FREQ) begin
      r = smax(th, zfl); // [RQ10]
    end else if (mode == cwoc_pkg::MODE_PW) begin
      if ($signed(th) <= $signed(cwoc_pkg::ZERO)) begin
        r = cwoc_pkg::MIN_POS; // [RQ12]
      end else begin
        r = smax(th, recip); // [RQ11]
      end
    end
    eff_th = r;
  endfunction : eff_th

  // Threshold less a hysteresis that only counts when positive.
  function automatic logic [31:0] hyst_level(input logic [31:0] th,
                                             input logic [31:0] h);
    hyst_level = ($signed(h) > $signed(cwoc_pkg::ZERO)) ? th - h : th;
  endfunction : hyst_level

  logic [cwoc_pkg::CTRL_W-1:0] ctrl;
  logic [31:0]                 upper_wrap_limit;
  logic [31:0]                 lower_wrap_limit;
  logic [31:0]                 zero_freq_limit;
  logic [31:0]                 count_preset;
  logic [31:0]                 rev_count_preset;
  logic [31:0]                 pulse_gap_timeout_us;
  logic [31:0]                 on_threshold;
  logic [31:0]                 off_threshold;
  logic [31:0]                 assert_hyst_offset;
  logic [31:0]                 release_hyst_offset;
  logic [cwoc_pkg::ST_W-1:0]   status;
  logic [cwoc_pkg::ST_W-1:0]   irq_enable;
  logic [31:0]                 count;
  logic [31:0]                 rev_count;
  logic [31:0]                 quad_err_count;
  logic [1:0]                  ab_q;
  logic                        z_q;
  logic [6:0]                  us_div;
  logic [31:0]                 gap_us;
  cwoc_pkg::cwoc_win_e         win_state;
  logic                        acc;
  logic                        wr;
  logic                        a_eff;
  logic                        b_eff;
  logic                        z_eff;
  logic                        step;
  logic                        up;
  logic                        quad_err;
  logic                        lead_edge;
  logic                        us_tick;
  logic                        gap_alarm;
  logic                        zero_freq;
  logic [1:0]                  mode;
  logic [31:0]                 recip;
  logic [31:0]                 on_meas;
  logic [31:0]                 off_meas;
  logic [31:0]                 on_level;
  logic [31:0]                 off_level;
  logic                        win_set;
  logic                        win_clr;
  logic [cwoc_pkg::ST_W-1:0]   ev;
  logic [cwoc_pkg::ST_W-1:0]   clr;
  logic                        load_cnt;
  logic                        load_rev;
  logic                        qerr_clr;
  logic [31:0]                 next_rdata;
  logic                        next_err;

  // Bus strobes.
  assign acc      = psel_i && penable_i && pready_o;
  assign wr       = acc && pwrite_i;
  assign load_cnt = wr_hit(cwoc_pkg::OFF_CMD, paddr_i, wr)
                    && pwdata_i[cwoc_pkg::CM_LOAD_CNT];
  assign load_rev = wr_hit(cwoc_pkg::OFF_CMD, paddr_i, wr)
                    && pwdata_i[cwoc_pkg::CM_LOAD_REV];
  assign qerr_clr = wr_hit(cwoc_pkg::OFF_CMD, paddr_i, wr)
                    && pwdata_i[cwoc_pkg::CM_QERR_CLR];
  assign clr      = wr_hit(cwoc_pkg::OFF_CLEAR, paddr_i, wr)
                    ? pwdata_i[cwoc_pkg::ST_W-1:0]
                    : '0;

  // Forced levels stand in for the pins before any decoding.
  assign a_eff = ctrl[cwoc_pkg::CT_A_EN] ? ctrl[cwoc_pkg::CT_A_LVL]
                                         : a_i; // [RQ6]
  assign b_eff = ctrl[cwoc_pkg::CT_B_EN] ? ctrl[cwoc_pkg::CT_B_LVL]
                                         : b_i; // [RQ6]
  assign z_eff = ctrl[cwoc_pkg::CT_Z_EN] ? ctrl[cwoc_pkg::CT_Z_LVL]
                                         : z_i; // [RQ6]

  // Quadrature decode; a double change is an error, not a count.
  assign step      = ({a_eff, b_eff} != ab_q);
  assign quad_err  = (a_eff != ab_q[1]) && (b_eff != ab_q[0]);
  assign up        = a_eff ^ ab_q[0];
  assign lead_edge = a_eff && !ab_q[1];

  // Pin history for edge and step detection.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ab_q <= 2'h0;
      z_q  <= 1'b0;
    end else begin
      ab_q <= {a_eff, b_eff};
      z_q  <= z_eff;
    end
  end

  // Running count with wrap; a load request beats a pulse.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count <= 32'h0;
    end else if (load_cnt) begin
      count <= count_preset; // [RQ5]
    end else if (step && !quad_err) begin
      if (up) begin
        count <= (count == upper_wrap_limit) ? lower_wrap_limit
                                             : count + 32'h1; // [RQ2]
      end else begin
        count <= (count == lower_wrap_limit) ? upper_wrap_limit
                                             : count - 32'h1; // [RQ3]
      end
    end
  end

  // Revolution count advances on each rising edge of Z.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rev_count <= 32'h0;
    end else if (load_rev) begin
      rev_count <= rev_count_preset; // [RQ5]
    end else if (z_eff && !z_q) begin
      rev_count <= rev_count + 32'h1;
    end
  end

  // Error count; an error in the clearing cycle still counts once.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      quad_err_count <= 32'h0;
    end else if (qerr_clr) begin
      quad_err_count <= quad_err ? 32'h1 : 32'h0; // [RQ1]
    end else if (quad_err) begin
      quad_err_count <= quad_err_count + 32'h1;
    end
  end

  // Microsecond tick from a free-running divider.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      us_div <= 7'h0;
    end else begin
      us_div <= (us_div == cwoc_pkg::US_LAST) ? 7'h0 : us_div + 7'h1;
    end
  end
  assign us_tick = (us_div == cwoc_pkg::US_LAST);

  // Elapsed microseconds since the last leading edge, saturating.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gap_us <= 32'h0;
    end else if (lead_edge) begin
      gap_us <= 32'h0;
    end else if (us_tick && (gap_us != 32'hffffffff)) begin
      gap_us <= gap_us + 32'h1;
    end
  end

  // The gap alarm needs its enable and a nonzero limit.
  assign gap_alarm = ctrl[cwoc_pkg::CT_GAP_EN] // [RQ17]
                     && (pulse_gap_timeout_us != 32'h0)
                     && (gap_us > pulse_gap_timeout_us); // [RQ7]

  // Zero frequency on either the live or the averaged figure.
  assign zero_freq = ($signed(freq_i) < $signed(zero_freq_limit))
                  || ($signed(freq_avg_i)
                      < $signed(zero_freq_limit)); // [RQ4]

  // Window measures and levels.
  assign mode  = ctrl[cwoc_pkg::CT_MODE_LO +: 2];
  assign recip = ($signed(zero_freq_limit) > $signed(cwoc_pkg::ZERO))
                 ? cwoc_pkg::PW_RECIP_NUM / zero_freq_limit
                 : cwoc_pkg::ZERO;

  // On side watches the average in average mode, off side acceleration.
  always_comb begin
    on_meas  = count;
    off_meas = count;
    case (mode)
      cwoc_pkg::MODE_COUNT: begin
        on_meas  = count;
        off_meas = count;
      end
      cwoc_pkg::MODE_FREQ: begin
        on_meas  = freq_i;
        off_meas = freq_i;
      end
      cwoc_pkg::MODE_PW: begin
        on_meas  = pulse_width_i;
        off_meas = pulse_width_i;
      end
      cwoc_pkg::MODE_AVG: begin
        on_meas  = freq_avg_i; // [RQ8]
        off_meas = accel_i; // [RQ9]
      end
      default: begin
        on_meas  = count;
        off_meas = count;
      end
    endcase
  end

  assign on_level  = hyst_level(eff_th(on_threshold, mode,
                                       zero_freq_limit, recip),
                                assert_hyst_offset); // [RQ13]
  assign off_level = hyst_level(eff_th(off_threshold, mode,
                                       zero_freq_limit, recip),
                                release_hyst_offset); // [RQ14]
  assign win_set = $signed(on_meas) >= $signed(on_level); // [RQ8]
  assign win_clr = $signed(off_meas) <= $signed(off_level); // [RQ9]

  // Window state machine; each state only watches its own exit.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      win_state <= cwoc_pkg::CWOC_WIN_OFF;
    end else begin
      case (win_state)
        cwoc_pkg::CWOC_WIN_OFF: begin
          if (win_set) begin
            win_state <= cwoc_pkg::CWOC_WIN_ON; // [RQ16]
          end
        end
        cwoc_pkg::CWOC_WIN_ON: begin
          if (win_clr) begin
            win_state <= cwoc_pkg::CWOC_WIN_OFF; // [RQ16]
          end
        end
        default: begin
          win_state <= cwoc_pkg::CWOC_WIN_OFF;
        end
      endcase
    end
  end

  // Physical output; forcing bypasses the window entirely.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      out_o <= 1'b0;
    end else if (ctrl[cwoc_pkg::CT_OUT_EN]) begin
      out_o <= ctrl[cwoc_pkg::CT_OUT_LVL]; // [RQ15]
    end else begin
      out_o <= (win_state == cwoc_pkg::CWOC_WIN_ON);
    end
  end

  // Events that latch into status.
  always_comb begin
    ev = '0;
    ev[cwoc_pkg::ST_UPPER]   = step && !quad_err && up && !load_cnt
                               && (count == upper_wrap_limit);
    ev[cwoc_pkg::ST_LOWER]   = step && !quad_err && !up && !load_cnt
                               && (count == lower_wrap_limit);
    ev[cwoc_pkg::ST_QERR]    = quad_err;
    ev[cwoc_pkg::ST_ZFREQ]   = zero_freq;
    ev[cwoc_pkg::ST_GAP]     = gap_alarm;
    ev[cwoc_pkg::ST_WIN_ON]  = (win_state == cwoc_pkg::CWOC_WIN_OFF)
                               && win_set;
    ev[cwoc_pkg::ST_WIN_OFF] = (win_state == cwoc_pkg::CWOC_WIN_ON)
                               && win_clr;
  end

  // Sticky status; a new event outranks a clear in the same cycle.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | ev; // [RQ18]
    end
  end

  // Interrupt level follows status one cycle later.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & irq_enable);
    end
  end

  // Software-written configuration.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl                 <= '0;
      upper_wrap_limit     <= 32'h0;
      lower_wrap_limit     <= 32'h0;
      zero_freq_limit      <= 32'h0;
      count_preset         <= 32'h0;
      rev_count_preset     <= 32'h0;
      pulse_gap_timeout_us <= 32'h0;
      on_threshold         <= 32'h0;
      off_threshold        <= 32'h0;
      assert_hyst_offset   <= 32'h0;
      release_hyst_offset  <= 32'h0;
      irq_enable           <= '0;
    end else if (wr) begin
      case (paddr_i)
        cwoc_pkg::OFF_CTRL:     ctrl <= pwdata_i[cwoc_pkg::CTRL_W-1:0];
        cwoc_pkg::OFF_UPPER:    upper_wrap_limit     <= pwdata_i;
        cwoc_pkg::OFF_LOWER:    lower_wrap_limit     <= pwdata_i;
        cwoc_pkg::OFF_ZFL:      zero_freq_limit      <= pwdata_i;
        cwoc_pkg::OFF_CPRE:     count_preset         <= pwdata_i;
        cwoc_pkg::OFF_RPRE:     rev_count_preset     <= pwdata_i;
        cwoc_pkg::OFF_GAP:      pulse_gap_timeout_us <= pwdata_i;
        cwoc_pkg::OFF_ON_TH:    on_threshold         <= pwdata_i;
        cwoc_pkg::OFF_OFF_TH:   off_threshold        <= pwdata_i;
        cwoc_pkg::OFF_HYST_ON:  assert_hyst_offset   <= pwdata_i;
        cwoc_pkg::OFF_HYST_OFF: release_hyst_offset  <= pwdata_i;
        cwoc_pkg::OFF_ENABLE:
          irq_enable <= pwdata_i[cwoc_pkg::ST_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; write-only registers read as zero, unmapped addresses flag an error.
  always_comb begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    case (paddr_i)
      cwoc_pkg::OFF_CTRL:     next_rdata = 32'(ctrl);
      cwoc_pkg::OFF_CMD:      next_rdata = 32'h0;
      cwoc_pkg::OFF_UPPER:    next_rdata = upper_wrap_limit;
      cwoc_pkg::OFF_LOWER:    next_rdata = lower_wrap_limit;
      cwoc_pkg::OFF_ZFL:      next_rdata = zero_freq_limit;
      cwoc_pkg::OFF_CPRE:     next_rdata = count_preset;
      cwoc_pkg::OFF_RPRE:     next_rdata = rev_count_preset;
      cwoc_pkg::OFF_GAP:      next_rdata = pulse_gap_timeout_us;
      cwoc_pkg::OFF_ON_TH:    next_rdata = on_threshold;
      cwoc_pkg::OFF_OFF_TH:   next_rdata = off_threshold;
      cwoc_pkg::OFF_HYST_ON:  next_rdata = assert_hyst_offset;
      cwoc_pkg::OFF_HYST_OFF: next_rdata = release_hyst_offset;
      cwoc_pkg::OFF_STATUS:   next_rdata = 32'(status);
      cwoc_pkg::OFF_CLEAR:    next_rdata = 32'h0;
      cwoc_pkg::OFF_ENABLE:   next_rdata = 32'(irq_enable);
      cwoc_pkg::OFF_COUNT:    next_rdata = count;
      cwoc_pkg::OFF_REV:      next_rdata = rev_count;
      cwoc_pkg::OFF_QERR:     next_rdata = quad_err_count;
      cwoc_pkg::OFF_LIVE:
        next_rdata = {27'h0, zero_freq, z_eff, b_eff, a_eff,
                      win_state == cwoc_pkg::CWOC_WIN_ON};
      default:                next_err   = 1'b1;
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      prdata_o  <= (psel_i && penable_i && !pwrite_i && !pready_o)
                   ? next_rdata : 32'h0;
      pslverr_o <= psel_i && penable_i && !pready_o && next_err;
    end
  end

endmodule : cwoc_top

/* File: tb/cwoc_checker.sv */
// Assertions on the bus handshake, output forcing and interrupt mask.
`timescale 1ns/10ps
module cwoc_checker (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        out_o,
  input wire logic        irq_o
);
  logic [1:0] sh_out;
  logic [6:0] sh_ie;
  logic       wr_ok;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // Shadow the forcing and mask bits, since the ports do not show them.
  assign wr_ok = psel_i && penable_i && pready_o && pwrite_i;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sh_out <= 2'h0;
      sh_ie  <= 7'h00;
    end else if (wr_ok && paddr_i == cwoc_pkg::OFF_CTRL) begin
      sh_out <= pwdata_i[8:7];
    end else if (wr_ok && paddr_i == cwoc_pkg::OFF_ENABLE) begin
      sh_ie <= pwdata_i[6:0];
    end
  end
  // A transfer is a setup cycle followed by exactly one wait.
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_answer;
    !pready_o ##1 pready_o;
  endsequence
  AST_ONE_WAIT: assert property (s_setup |=> s_answer)
    else $error("access did not end after exactly one wait");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  AST_IDLE_QUIET: assert property (!psel_i |=> !pready_o)
    else $error("ready without a selected transfer");
  AST_ERR_DECODE: assert property (pready_o && paddr_i[1:0] == 2'h0
    |-> pslverr_o == (paddr_i > cwoc_pkg::OFF_LIVE))
    else $error("error response does not match the address map");
  AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero outside the answer cycle");
  AST_WO_ZERO: assert property (pready_o && !pwrite_i
    && (paddr_i == cwoc_pkg::OFF_CMD || paddr_i == cwoc_pkg::OFF_CLEAR)
    |-> prdata_o == 32'h0)
    else $error("write-only register read back non-zero");
  AST_OUT_FORCE: assert property (sh_out[0] && $stable(sh_out)
    && $past(sh_out) == $past(sh_out, 2) |-> out_o == sh_out[1])
    else $error("forced output level not on the pin");
  AST_IRQ_MASKED: assert property (sh_ie == 7'h00
    && $past(sh_ie) == 7'h00 && $past(sh_ie, 2) == 7'h00 |-> !irq_o)
    else $error("interrupt raised with every source masked");
endmodule : cwoc_checker

bind cwoc_top cwoc_checker chk (.clock_i, .rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
  .out_o, .irq_o);

/* File: tb/cwoc_encoder.sv */
// Quadrature source model driving the A, B and index pins.
`timescale 1ns/10ps
module cwoc_encoder (
  input  wire logic clock_i,
  input  wire logic step_i,
  input  wire logic down_i,
  input  wire logic both_i,
  input  wire logic idx_i,
  output logic      a_o,
  output logic      b_o,
  output logic      z_o
);
  logic [1:0] ph = 2'h0;
  // One gray step per request; both lines jump only when told to.
  always @(posedge clock_i) begin
    if (both_i) begin
      ph <= ph + 2'h2;
    end else if (step_i) begin
      ph <= down_i ? ph - 2'h1 : ph + 2'h1;
    end
    z_o <= idx_i;
  end
  assign a_o = ph[0] ^ ph[1];
  assign b_o = ph[1];
endmodule : cwoc_encoder

/* File: tb/tb.sv */
// Self-checking bench for the counter channel and its register bus.
`timescale 1ns/10ps
module tb;
  logic        clock_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, step = 1'b0;
  logic        penable_i = 1'b0, pwrite_i = 1'b0, down = 1'b0;
  logic        both = 1'b0, idx = 1'b0, ew;
  logic        pready_o, pslverr_o, a_i, b_i, z_i, out_o, irq_o;
  logic [7:0]  paddr_i = 8'h00;
  logic [10:0] ctl;
  logic [31:0] pwdata_i = 32'h0, freq_i = 32'h0, pulse_width_i = 32'h0;
  logic [31:0] freq_avg_i = 32'h0, accel_i = 32'h0, prdata_o, q, pre;
  int          n_errors = 0, checked = 0, v;
  int          cv[7] = '{32'h61a8, 32'h4b, 32'h4e02, 32'h2328, 32'h2af8,
                         32'h0, 32'h2300};
  always #5 clock_i = ~clock_i;
  cwoc_top dut (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .a_i, .b_i,
    .z_i, .freq_i, .freq_avg_i, .pulse_width_i, .accel_i, .out_o, .irq_o);
  cwoc_encoder enc (.clock_i, .step_i(step), .down_i(down),
    .both_i(both), .idx_i(idx), .a_o(a_i), .b_o(b_i), .z_o(z_i));
  // Verdict and end of run, also reached when a wait runs out.
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One bus transfer; the request stands until ready is seen high.
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    q = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
    if (n >= 20) begin
      n_errors++;
      summarize();
    end
  endtask : apb
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, e);
    apb(1'b0, ad, 32'h0);
    check(q & m, e);
  endtask : rd
  task automatic mv(input logic dn, input logic bo);
    step <= 1'b1;
    down <= dn;
    both <= bo;
    @(posedge clock_i);
    step <= 1'b0;
    both <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : mv
  // Effective window level, with a zero-frequency limit of 100 Hz.
  function automatic int lvl(input int md, input int th, input int h);
    int r;
    r = th;
    if (md == 1 && r < 32'sh64) r = 32'sh64;
    if (md == 2) r = (r <= 0) ? 1 : ((r < 32'sh2710) ? 32'sh2710 : r);
    return (h > 0) ? r - h : r;
  endfunction : lvl
  // Main sequence: wrap, presets, errors, forcing, gap alarm, window.
  initial begin
    void'($urandom(55296));
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rd(cwoc_pkg::OFF_CTRL, 32'hffffffff, 32'h0);
    rd(8'h80, 32'hffffffff, 32'h0);
    apb(1'b1, cwoc_pkg::OFF_UPPER, 32'h3);
    apb(1'b1, cwoc_pkg::OFF_LOWER, 32'hfffffffe);
    repeat (3) mv(1'b0, 1'b0);
    rd(cwoc_pkg::OFF_COUNT, 32'hffffffff, 32'h3);
    mv(1'b0, 1'b0);
    rd(cwoc_pkg::OFF_COUNT, 32'hffffffff, 32'hfffffffe);
    mv(1'b1, 1'b0);
    rd(cwoc_pkg::OFF_COUNT, 32'hffffffff, 32'h3);
    rd(cwoc_pkg::OFF_STATUS, 32'h3, 32'h3);
    apb(1'b1, cwoc_pkg::OFF_ENABLE, 32'h1);
    @(posedge clock_i);
    check({31'h0, irq_o}, 32'h1);
    apb(1'b1, cwoc_pkg::OFF_CLEAR, 32'h1);
    rd(cwoc_pkg::OFF_STATUS, 32'h3, 32'h2);
    check({31'h0, irq_o}, 32'h0);
    pre = $urandom;
    apb(1'b1, cwoc_pkg::OFF_CPRE, pre);
    apb(1'b1, cwoc_pkg::OFF_RPRE, ~pre);
    apb(1'b1, cwoc_pkg::OFF_CMD, 32'h3);
    rd(cwoc_pkg::OFF_COUNT, 32'hffffffff, pre);
    rd(cwoc_pkg::OFF_REV, 32'hffffffff, ~pre);
    mv(1'b0, 1'b1);
    rd(cwoc_pkg::OFF_QERR, 32'hffffffff, 32'h1);
    apb(1'b1, cwoc_pkg::OFF_CMD, 32'h4);
    rd(cwoc_pkg::OFF_QERR, 32'hffffffff, 32'h0);
    // Random forcing of the pins, with the output forced both ways.
    for (int i = 0; i < 6; i++) begin
      ctl = {2'h0, i[0], 1'b1, 1'b0, 6'($urandom)};
      idx <= 1'($urandom);
      apb(1'b1, cwoc_pkg::OFF_CTRL, {21'h0, ctl});
      repeat (3) @(posedge clock_i);
      rd(cwoc_pkg::OFF_LIVE, 32'he, {28'h0, ctl[4] ? ctl[5] : z_i,
        ctl[2] ? ctl[3] : b_i, ctl[0] ? ctl[1] : a_i, 1'b0});
      check({31'h0, out_o}, {31'h0, ctl[8]});
    end
    // Gap alarm of 2 us: silent while disabled, raised once enabled.
    apb(1'b1, cwoc_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, cwoc_pkg::OFF_GAP, 32'h2);
    apb(1'b1, cwoc_pkg::OFF_CLEAR, 32'h7f);
    repeat (400) @(posedge clock_i);
    rd(cwoc_pkg::OFF_STATUS, 32'h10, 32'h0);
    apb(1'b1, cwoc_pkg::OFF_CTRL, 32'h40);
    repeat (400) @(posedge clock_i);
    rd(cwoc_pkg::OFF_STATUS, 32'h10, 32'h10);
    apb(1'b1, cwoc_pkg::OFF_ZFL, 32'h64);
    apb(1'b1, cwoc_pkg::OFF_ON_TH, 32'h2328);
    apb(1'b1, cwoc_pkg::OFF_OFF_TH, 32'h0);
    apb(1'b1, cwoc_pkg::OFF_HYST_ON, 32'h28);
    apb(1'b1, cwoc_pkg::OFF_HYST_OFF, 32'hfffffffb);
    // Frequency, pulse width and average modes; corners then random.
    for (int m = 1; m <= 3; m++) begin
      {freq_i, pulse_width_i, freq_avg_i, accel_i} <= 128'h0;
      apb(1'b1, cwoc_pkg::OFF_CTRL, 32'(m) << 9);
      repeat (3) @(posedge clock_i);
      ew = 1'b0;
      for (int k = 0; k < 14; k++) begin
        v = (k < 7) ? cv[k] : int'($urandom_range(32'h7530));
        {freq_i, pulse_width_i, freq_avg_i, accel_i} <= {4{32'(v)}};
        repeat (3) @(posedge clock_i);
        if (ew) ew = !(v <= lvl(m, 32'sh0, -5));
        else ew = v >= lvl(m, 32'sh2328, 32'sh28);
        rd(cwoc_pkg::OFF_LIVE, 32'h1, {31'h0, ew});
        check({31'h0, out_o}, {31'h0, ew});
      end
    end
    rd(cwoc_pkg::OFF_STATUS, 32'h8, 32'h8);
    summarize();
  end
endmodule : tb
